// ### fae_host_model.sv
// serial host model that frames flash commands on the link
`timescale 1ns/1ps
module fae_host_model (
  // link outputs
  output logic sck,
  output logic cs_n,
  output logic si
);
  // link clock half period; the clock stands still between frames
  localparam realtime HALF = 80.0;

  // ---------------------------------------------------------------
  // idle link at time zero
  // ---------------------------------------------------------------
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // ---------------------------------------------------------------
  // one command frame, msb first, n bits from the top of bits
  // ---------------------------------------------------------------
  // any bit count sent, so a field may be cut short
  task automatic frame(input logic [47:0] bits, input int n);
    #3.3;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      si = bits[47-i];
      #(HALF);
      sck = 1'b1;
      #(HALF);
      sck = 1'b0;
    end
    #(HALF);
    cs_n = 1'b1;
    // released line shows the inverse, so a stale bit is never reused
    si = ~si;
    #(HALF*3);
  endtask
endmodule

// ### fae_params.svh
// constants for the flash address extension block
`ifndef FAE_PARAMS_SVH
`define FAE_PARAMS_SVH

// ---------------------------------------------------------------
// command opcodes
// ---------------------------------------------------------------
`define FAE_OPC_READ 8'h03
`define FAE_OPC_FAST 8'h0b
`define FAE_OPC_PROG 8'h02
`define FAE_OPC_ERASE 8'hd8
`define FAE_OPC_READ4 8'h13
`define FAE_OPC_FAST4 8'h0c
`define FAE_OPC_PROG4 8'h12
`define FAE_OPC_ERASE4 8'hdc
`define FAE_OPC_BANK_WR 8'h17
`define FAE_OPC_OTP_RD 8'h4b

// ---------------------------------------------------------------
// frame layout and bit counts
// ---------------------------------------------------------------
`define FAE_CNT_W 6
`define FAE_OPC_BITS 8
`define FAE_BANK_BITS 8
`define FAE_ADDR_LEGACY 24
`define FAE_ADDR_FULL 32

// ---------------------------------------------------------------
// bank register fields and reset value
// ---------------------------------------------------------------
`define FAE_BANK_EXT 7
`define FAE_BANK_HI 6
`define FAE_BANK_RST 8'h00

`endif

// ### fae_pkg.sv
// types shared by the flash address extension block
package fae_pkg;

  // ---------------------------------------------------------------
  // link frame states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    FAE_OPC  = 4'b0001,
    FAE_BANK = 4'b0010,
    FAE_ADDR = 4'b0100,
    FAE_IDLE = 4'b1000
  } fae_state_type;

  // ---------------------------------------------------------------
  // command classes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FAE_CL_NONE   = 3'h0,
    FAE_CL_LEGACY = 3'h1,
    FAE_CL_NEW    = 3'h2,
    FAE_CL_OTP    = 3'h3,
    FAE_CL_BANKWR = 3'h4
  } fae_class_type;

endpackage

// ### fae_shift.sv
// serial input shifter with frame bit counter
`timescale 1ns/1ps
`include "fae_params.svh"
module fae_shift #(
  parameter int W = 32
) (
  // link clock, cleared while the frame is closed
  input wire logic clk,
  input wire logic arst,
  // serial data
  input wire logic din,
  // shifted word and bits taken so far
  output logic [W-1:0] sh,
  output logic [`FAE_CNT_W-1:0] cnt
);

  logic [W-1:0] sh_r, sh_nxt;
  logic [`FAE_CNT_W-1:0] cnt_r, cnt_nxt;

  // ---------------------------------------------------------------
  // shift and count
  // ---------------------------------------------------------------
  // count saturates so long frames never wrap into a fake phase
  always_comb begin
    sh_nxt = {sh_r[W-2:0], din};
    cnt_nxt = (&cnt_r) ? cnt_r : cnt_r + `FAE_CNT_W'(1);
  end

  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      sh_r <= '0;
      cnt_r <= '0;
    end else begin
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign sh = sh_r;
  assign cnt = cnt_r;

endmodule

// ### fae_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module fae_sync #(
  parameter int W = 1
) (
  // destination clock and reset
  input wire logic clk,
  input wire logic arst,
  // level in, filtered level out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_r, s2_r, s3_r, q_r;
  logic [W-1:0] q_nxt;

  // ---------------------------------------------------------------
  // filter
  // ---------------------------------------------------------------
  // a bit only moves once the second and third stages agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q_r[i];
    end
  end

  // stage one feeds stage two only
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

// ### fae_top.sv
// flash address extension: bank register and address forming
`timescale 1ns/1ps
`include "fae_params.svh"
module fae_top #(
  parameter bit SMALL_PART = 1'b0
) (
  // core clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  // resolved address
  output logic addr_valid,
  output logic [`FAE_ADDR_FULL-1:0] addr,
  output logic [`FAE_OPC_BITS-1:0] opcode,
  output logic otp_space,
  output logic addr_wide,
  // bank state
  output logic [`FAE_BANK_BITS-1:0] bank,
  output logic extend
);
  import fae_pkg::*;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  function automatic fae_class_type opc_class(
    input logic [`FAE_OPC_BITS-1:0] o
  );
    fae_class_type c;
    c = FAE_CL_NONE;
    case (o)
      `FAE_OPC_READ, `FAE_OPC_FAST,
      `FAE_OPC_PROG, `FAE_OPC_ERASE: c = FAE_CL_LEGACY;
      `FAE_OPC_READ4, `FAE_OPC_FAST4,
      `FAE_OPC_PROG4, `FAE_OPC_ERASE4: c = FAE_CL_NEW;
      `FAE_OPC_OTP_RD: c = FAE_CL_OTP;
      `FAE_OPC_BANK_WR: c = FAE_CL_BANKWR;
      default: c = FAE_CL_NONE;
    endcase
    return c;
  endfunction

  localparam logic [`FAE_CNT_W-1:0] OPC_LAST =
    `FAE_CNT_W'(`FAE_OPC_BITS - 1);
  localparam logic [`FAE_CNT_W-1:0] BANK_LAST =
    `FAE_CNT_W'(`FAE_OPC_BITS + `FAE_BANK_BITS - 1);
  localparam logic [`FAE_CNT_W-1:0] A24_LAST =
    `FAE_CNT_W'(`FAE_OPC_BITS + `FAE_ADDR_LEGACY - 1);
  localparam logic [`FAE_CNT_W-1:0] A32_LAST =
    `FAE_CNT_W'(`FAE_OPC_BITS + `FAE_ADDR_FULL - 1);

  // ---------------------------------------------------------------
  // link-side reset
  // ---------------------------------------------------------------
  // the link clock may stand still, so link state is cleared
  // asynchronously: frame state by chip select, all of it by reset
  logic link_rst_r;
  logic frame_rst;

  always_ff @(posedge clk) begin
    link_rst_r <= rst;
  end

  assign frame_rst = cs_n | link_rst_r;

  // ---------------------------------------------------------------
  // link frame state (sck domain)
  // ---------------------------------------------------------------
  fae_state_type st_r, st_nxt;
  logic len32_r, len32_nxt;
  logic [`FAE_ADDR_FULL-1:0] sh;
  logic [`FAE_ADDR_FULL-1:0] word_now;
  logic [`FAE_CNT_W-1:0] cnt;
  logic [`FAE_CNT_W-1:0] addr_last;
  logic ext_link;
  fae_class_type cls_now;
  // bank register lives in the core domain; declared here for the sync
  logic [`FAE_BANK_BITS-1:0] bank_r, bank_nxt;

  fae_shift #(.W(`FAE_ADDR_FULL)) u_shift (
    .clk(sck),
    .arst(frame_rst),
    .din(si),
    .sh(sh),
    .cnt(cnt)
  );

  // extend bit seen by the link logic; settles within the opcode
  fae_sync #(.W(1)) u_ext_sync (
    .clk(sck),
    .arst(link_rst_r),
    .d(bank_r[`FAE_BANK_EXT]),
    .q(ext_link)
  );

  assign word_now = {sh[`FAE_ADDR_FULL-2:0], si};
  assign cls_now = opc_class(word_now[`FAE_OPC_BITS-1:0]);
  assign addr_last = len32_r ? A32_LAST : A24_LAST;

  // choose address length once, at the last opcode bit
  always_comb begin
    st_nxt = st_r;
    len32_nxt = len32_r;
    unique case (st_r)
      FAE_OPC: begin
        if (cnt == OPC_LAST) begin
          unique case (cls_now)
            FAE_CL_LEGACY: begin
              st_nxt = FAE_ADDR;
              len32_nxt = ext_link;
            end
            FAE_CL_NEW, FAE_CL_OTP: begin
              st_nxt = FAE_ADDR;
              len32_nxt = 1'b1;
            end
            FAE_CL_BANKWR: st_nxt = FAE_BANK;
            FAE_CL_NONE: st_nxt = FAE_IDLE;
          endcase
        end
      end
      FAE_BANK: begin
        if (cnt == BANK_LAST) begin
          st_nxt = FAE_IDLE;
        end
      end
      FAE_ADDR: begin
        if (cnt == addr_last) begin
          st_nxt = FAE_IDLE;
        end
      end
      FAE_IDLE: st_nxt = FAE_IDLE;
    endcase
  end

  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      st_r <= FAE_OPC;
      len32_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      len32_r <= len32_nxt;
    end
  end

  // ---------------------------------------------------------------
  // captured words handed to the core (sck domain)
  // ---------------------------------------------------------------
  // words stay stable until the next capture, so the core samples
  // them after the toggle has crossed
  logic [`FAE_OPC_BITS-1:0] opc_r, opc_nxt;
  logic [`FAE_OPC_BITS-1:0] aopc_r, aopc_nxt;
  logic [`FAE_ADDR_FULL-1:0] word_r, word_nxt;
  logic word32_r, word32_nxt;
  logic [`FAE_BANK_BITS-1:0] bank_byte_r, bank_byte_nxt;
  logic addr_tgl_r, addr_tgl_nxt;
  logic bank_tgl_r, bank_tgl_nxt;

  always_comb begin
    opc_nxt = opc_r;
    aopc_nxt = aopc_r;
    word_nxt = word_r;
    word32_nxt = word32_r;
    bank_byte_nxt = bank_byte_r;
    addr_tgl_nxt = addr_tgl_r;
    bank_tgl_nxt = bank_tgl_r;
    if (st_r == FAE_OPC && cnt == OPC_LAST) begin
      opc_nxt = word_now[`FAE_OPC_BITS-1:0];
    end
    if (st_r == FAE_ADDR && cnt == addr_last) begin
      aopc_nxt = opc_r;
      word_nxt = word_now;
      word32_nxt = len32_r;
      addr_tgl_nxt = ~addr_tgl_r;
    end
    // bank byte complete, pass it on
    if (st_r == FAE_BANK && cnt == BANK_LAST) begin
      bank_byte_nxt = word_now[`FAE_BANK_BITS-1:0];
      bank_tgl_nxt = ~bank_tgl_r;
    end
  end

  always_ff @(posedge sck or posedge link_rst_r) begin
    if (link_rst_r) begin
      opc_r <= '0;
      aopc_r <= '0;
      word_r <= '0;
      word32_r <= 1'b0;
      bank_byte_r <= `FAE_BANK_RST;
      addr_tgl_r <= 1'b0;
      bank_tgl_r <= 1'b0;
    end else begin
      opc_r <= opc_nxt;
      aopc_r <= aopc_nxt;
      word_r <= word_nxt;
      word32_r <= word32_nxt;
      bank_byte_r <= bank_byte_nxt;
      addr_tgl_r <= addr_tgl_nxt;
      bank_tgl_r <= bank_tgl_nxt;
    end
  end

  // ---------------------------------------------------------------
  // core side (clk domain)
  // ---------------------------------------------------------------
  logic [1:0] tgl_q;
  logic [1:0] seen_r, seen_nxt;
  logic addr_ev, bank_ev;
  logic extend_r, extend_nxt;
  logic addr_valid_r, addr_valid_nxt;
  logic [`FAE_ADDR_FULL-1:0] addr_r, addr_nxt;
  logic [`FAE_OPC_BITS-1:0] opcode_r, opcode_nxt;
  logic otp_r, otp_nxt;
  logic wide_r, wide_nxt;
  logic is_otp;

  fae_sync #(.W(2)) u_evt_sync (
    .clk(clk),
    .arst(rst),
    .d({bank_tgl_r, addr_tgl_r}),
    .q(tgl_q)
  );

  assign addr_ev = tgl_q[0] ^ seen_r[0];
  assign bank_ev = tgl_q[1] ^ seen_r[1];
  assign is_otp = (opc_class(aopc_r) == FAE_CL_OTP);

  always_comb begin
    seen_nxt = tgl_q;
    bank_nxt = bank_r;
    addr_nxt = addr_r;
    opcode_nxt = opcode_r;
    otp_nxt = otp_r;
    wide_nxt = wide_r;
    addr_valid_nxt = addr_ev;
    if (bank_ev) begin
      bank_nxt = bank_byte_r;
    end
    if (addr_ev) begin
      opcode_nxt = aopc_r;
      otp_nxt = is_otp;
      wide_nxt = word32_r;
      if (word32_r) begin
        addr_nxt = word_r;
      end else begin
        addr_nxt = {1'b0, bank_r[`FAE_BANK_HI:0],
                    word_r[`FAE_ADDR_LEGACY-1:0]};
      end
      // small array decodes only the low bits
      if (SMALL_PART && !is_otp) begin
        addr_nxt[`FAE_ADDR_FULL-1:`FAE_ADDR_LEGACY] = '0;
      end
    end
    extend_nxt = bank_nxt[`FAE_BANK_EXT];
  end

  // reset clears bank and selects 24-bit mode
  always_ff @(posedge clk) begin
    if (rst) begin
      seen_r <= 2'h0;
      bank_r <= `FAE_BANK_RST;
      extend_r <= 1'b0;
      addr_valid_r <= 1'b0;
      addr_r <= '0;
      opcode_r <= '0;
      otp_r <= 1'b0;
      wide_r <= 1'b0;
    end else begin
      seen_r <= seen_nxt;
      bank_r <= bank_nxt;
      extend_r <= extend_nxt;
      addr_valid_r <= addr_valid_nxt;
      addr_r <= addr_nxt;
      opcode_r <= opcode_nxt;
      otp_r <= otp_nxt;
      wide_r <= wide_nxt;
    end
  end

  assign addr_valid = addr_valid_r;
  assign addr = addr_r;
  assign opcode = opcode_r;
  assign otp_space = otp_r;
  assign addr_wide = wide_r;
  assign bank = bank_r;
  assign extend = extend_r;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence opc_done_s;
    st_r == FAE_OPC && cnt == OPC_LAST;
  endsequence

  sequence addr_done_s;
    st_r == FAE_ADDR && cnt == addr_last;
  endsequence

  legacy_len_a: assert property (@(posedge sck) disable iff (frame_rst)
    (opc_done_s ##0 cls_now == FAE_CL_LEGACY) |=> len32_r == $past(ext_link))
    else $error("legacy length not taken from extend bit");

  new_len_a: assert property (@(posedge sck) disable iff (frame_rst)
    (opc_done_s ##0 (cls_now == FAE_CL_NEW || cls_now == FAE_CL_OTP))
    |=> len32_r && st_r == FAE_ADDR)
    else $error("new command not set to 32-bit address");

  len_hold_a: assert property (@(posedge sck) disable iff (frame_rst)
    st_r == FAE_ADDR |=> $stable(len32_r))
    else $error("address length changed mid-command");

  addr_end_a: assert property (@(posedge sck) disable iff (frame_rst)
    addr_done_s |=> addr_tgl_r != $past(addr_tgl_r) && st_r == FAE_IDLE
      && word_r == $past(word_now))
    else $error("address phase did not close on its last bit");

  reset_clear_a: assert property (@(posedge clk)
    rst |=> bank_r == `FAE_BANK_RST && !extend_r && !addr_valid_r)
    else $error("reset did not clear bank register");

  bank_load_a: assert property (@(posedge clk) disable iff (rst)
    bank_ev |=> bank_r == $past(bank_byte_r)
      && extend_r == $past(bank_byte_r[`FAE_BANK_EXT]))
    else $error("bank register not loaded");

  bank_hold_a: assert property (@(posedge clk) disable iff (rst)
    !bank_ev |=> $stable(bank_r))
    else $error("bank register changed without a load");

  merge_low_a: assert property (@(posedge clk) disable iff (rst)
    (addr_ev && !word32_r && !SMALL_PART) |=> addr_valid_r
      && addr_r == {1'b0, $past(bank_r[`FAE_BANK_HI:0]),
                    $past(word_r[`FAE_ADDR_LEGACY-1:0])})
    else $error("legacy address not merged with bank");

  full_word_a: assert property (@(posedge clk) disable iff (rst)
    (addr_ev && word32_r && (!SMALL_PART || is_otp))
    |=> addr_r == $past(word_r) && wide_r)
    else $error("full address not passed through");

  small_top_a: assert property (@(posedge clk) disable iff (rst)
    (addr_ev && SMALL_PART && !is_otp) |=> addr_r[31:24] == 8'h00)
    else $error("small part kept high address byte");

endmodule

// ### fae_top_tb.sv
// self-checking bench for the flash address extension block
`timescale 1ns/1ps
`include "fae_params.svh"
module fae_top_tb;
  logic clk;
  logic rst;
  logic sck;
  logic cs_n;
  logic si;
  logic av;
  logic [31:0] addr;
  logic [7:0] opcode;
  logic otp;
  logic wide;
  logic [7:0] bank;
  logic extend;
  logic av2;
  logic [31:0] addr2;
  int error_cnt = 0;
  int check_count = 0;
  int pulses = 0;
  int pulses2 = 0;
  int cycles = 0;
  logic [7:0] leg [4] = '{`FAE_OPC_READ, `FAE_OPC_FAST, `FAE_OPC_PROG,
                          `FAE_OPC_ERASE};
  logic [7:0] nw [4] = '{`FAE_OPC_READ4, `FAE_OPC_FAST4, `FAE_OPC_PROG4,
                         `FAE_OPC_ERASE4};

  // ---------------------------------------------------------------
  // clock, far side and the two part sizes on one shared link
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  fae_host_model host (.sck(sck), .cs_n(cs_n), .si(si));

  fae_top #(.SMALL_PART(1'b0)) DUT (.clk(clk), .rst(rst), .sck(sck),
    .cs_n(cs_n), .si(si), .addr_valid(av), .addr(addr), .opcode(opcode),
    .otp_space(otp), .addr_wide(wide), .bank(bank), .extend(extend));

  fae_top #(.SMALL_PART(1'b1)) DUT2 (.clk(clk), .rst(rst), .sck(sck),
    .cs_n(cs_n), .si(si), .addr_valid(av2), .addr(addr2), .opcode(),
    .otp_space(), .addr_wide(), .bank(), .extend());

  // pulse counters and hang guard; a run needs about 12250 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (av === 1'b1) pulses <= pulses + 1;
    if (av2 === 1'b1) pulses2 <= pulses2 + 1;
    if (cycles == 25000) begin
      error_cnt++;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one address command; small part drops the top byte outside otp
  task automatic cmd(input logic [7:0] opc, input logic [31:0] a,
    input int na, input logic [31:0] ea, input logic ew, input logic eo);
    int p0;
    int q0;
    p0 = pulses;
    q0 = pulses2;
    // one trailing bit past the address, which the device must ignore
    host.frame((na == 32) ? {opc, a, 8'h00} : {opc, a[23:0], 16'h0000},
      9 + na);
    @(posedge clk);
    #1;
    check(32'(pulses - p0), 32'h1);
    check(32'(pulses2 - q0), 32'h1);
    check(addr, ea);
    check(addr2, eo ? ea : {8'h00, ea[23:0]});
    check(opcode, opc);
    check(wide, ew);
    check(otp, eo);
  endtask

  task automatic bank_wr(input logic [7:0] b);
    int p0;
    p0 = pulses;
    host.frame({`FAE_OPC_BANK_WR, b, 32'h0}, 17);
    @(posedge clk);
    #1;
    check(bank, b);
    check(extend, b[7]);
    check(32'(pulses - p0), 32'h0);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    check(bank, 8'h00);
    check(extend, 1'b0);
    check(av, 1'b0);
  endtask

  // bank zero: only the lowest 16 MB reachable
  task automatic t_legacy();
    for (int i = 0; i < 4; i++)
      cmd(leg[i], 32'h00ab_cde0 + i, 24, 32'h00ab_cde0 + i, 1'b0, 1'b0);
  endtask

  // highest bank value, then the four-byte commands ignore the bank
  task automatic t_bank_new();
    bank_wr(8'h7f);
    for (int i = 0; i < 4; i++)
      cmd(leg[i], 32'h0012_3450 + i, 24, 32'h7f12_3450 + i, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++)
      cmd(nw[i], 32'hfedc_ba90 + i, 32, 32'hfedc_ba90 + i, 1'b1, 1'b0);
  endtask

  // extend mode applies from the very next frame
  task automatic t_extend();
    bank_wr(8'h80);
    cmd(`FAE_OPC_READ, 32'h89ab_cdef, 32, 32'h89ab_cdef, 1'b1, 1'b0);
    bank_wr(8'h03);
    cmd(`FAE_OPC_FAST, 32'h0000_0001, 24, 32'h0300_0001, 1'b0, 1'b0);
  endtask

  // otp space keeps all 32 bits, on the small part too
  task automatic t_otp();
    cmd(`FAE_OPC_OTP_RD, 32'h5a00_03ff, 32, 32'h5a00_03ff, 1'b1, 1'b1);
  endtask

  // unknown opcode and cut frames are dropped: no pulse, state held
  task automatic t_refuse();
    int p0;
    logic [7:0] b0;
    p0 = pulses;
    b0 = bank;
    host.frame({8'h5c, 40'hff_ffff_ffff}, 41);
    host.frame({`FAE_OPC_READ, 40'h12_3456_0000}, 20);
    host.frame({`FAE_OPC_BANK_WR, 8'h55, 32'h0}, 12);
    @(posedge clk);
    #1;
    check(32'(pulses - p0), 32'h0);
    check(bank, b0);
    check(addr, 32'h5a00_03ff);
  endtask

  // second reset in mid-run returns to 24-bit bank zero
  task automatic t_rerst();
    bank_wr(8'hff);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    t_reset();
    cmd(`FAE_OPC_PROG, 32'h00ff_ffff, 24, 32'h00ff_ffff, 1'b0, 1'b0);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    t_reset();
    t_legacy();
    t_bank_new();
    t_extend();
    t_otp();
    t_refuse();
    t_rerst();
    conclude();
  end
endmodule
